/* File: include/nts_pkg.sv */
// Package with constants for the NFC tag SPI host port
package nts_pkg;
   // ----------------------------------------------------------------
   // Operation codes (top three bits of the first byte; direct command uses the top two)
   // ----------------------------------------------------------------
   localparam logic [2:0] OP_REG_WR  = 3'h0;
   localparam logic [2:0] OP_REG_RD  = 3'h1;
   localparam logic [2:0] OP_EE_WR   = 3'h2;
   localparam logic [2:0] OP_EE_RD   = 3'h3;
   localparam logic [2:0] OP_BUF_LD  = 3'h4;
   localparam logic [2:0] OP_BUF_RD  = 3'h5;
   localparam logic [1:0] OP_CMD     = 2'h3;
   // ----------------------------------------------------------------
   // Field layout and sizes
   // ----------------------------------------------------------------
   localparam int         BYTE_W     = 8;
   localparam int         REG_AW     = 5;
   localparam int         BLK_AW     = 7;
   localparam int         BUF_AW     = 5;
   localparam logic [5:0] BUF_DEPTH  = 6'h20;
   localparam logic [2:0] EE_BYTES   = 3'h4;
   localparam int         ARBIT_BIT  = 3;
   localparam logic [7:0] ARG_ACCEPT = 8'h01;
   localparam logic [7:0] ARG_REJECT = 8'h02;
   localparam logic [2:0] BIT_LAST   = 3'h7;
   localparam int         FIFO_DEPTH = 8;
   localparam logic [3:0] ERR_NONE   = 4'h0;
endpackage : nts_pkg

/* File: rtl/nts_spi_port.sv */
// SPI slave host port of a dynamic NFC tag, with its write FIFO
// Functional notes
// - First byte's top three bits select operation; register modes carry 5-bit address.
// - Slave-select high holds serial logic in reset, dropping partial transactions.
// - Serial output is high impedance except while shifting read data.
// - Serial input is sampled on falling clock edge, MSB first.
// - Register write: start address, then data bytes to incrementing addresses.
// - Each register data byte commits on the falling edge of its eighth bit.
// - A write byte cut short by slave-select rising is not stored.
// - Writes to missing or read-only registers are dropped silently.
// - Register read: address then data bytes out, address auto-increments.
// - Read bits launch on rising edge; master captures on falling edge.
// - Reads of missing registers return zero.
// - Priority bit 3 set gives RF precedence over host on the EEPROM.
// - Under RF priority, RF activity aborts host EEPROM write and flags access error.
// - Block address byte holds seven address bits; bit 0 ignored.
// - EEPROM programming starts only when slave-select rises.
// - EEPROM read streams 4-byte blocks, block address incrementing each block.
// - Reads of missing EEPROM blocks return zero.
// - Code 100b loads transmit buffer, up to 32 bytes.
// - Code 101b reads bytes from the receive buffer.
// - A buffer read byte cut short by slave-select still counts consumed.
// - Direct command: 11b plus six-bit code, then an argument byte returned.
// - Argument byte is 01h when accepted, 02h when rejected by priority.
`timescale 1ns/1ns

// --------------------------------------------------------------------
// Synchronous FIFO of flip-flops
// --------------------------------------------------------------------
module nts_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys, // System clock
   input  wire logic             rst,     // Synchronous reset
   input  wire logic [WIDTH-1:0] in_data, // Write data
   input  wire logic             in_valid,// Write request
   output logic                  in_ready,// Space available
   output logic      [WIDTH-1:0] out_data,// Head data
   output logic                  out_valid,// Head valid
   input  wire logic             out_ready // Drain accepts
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, rd_q;
   logic [AW:0]      cnt_q;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // Flags from the occupancy count
   assign in_ready  = (cnt_q < (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   // Pointer and count update
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Storage write
   always_ff @(posedge clk_sys) begin
      if (push) mem_q[wr_q] <= in_data;
   end
endmodule : nts_fifo

// --------------------------------------------------------------------
// Port top level
// --------------------------------------------------------------------
module nts_spi_port (
   input  wire logic                         clk_sys,       // 20 MHz system clock
   input  wire logic                         rst,           // Synchronous reset
   input  wire logic                         ss_n,          // Slave select pin
   input  wire logic                         sclk,          // Serial clock pin
   input  wire logic                         mosi,          // Serial data in pin
   output logic                              miso_o,        // Serial data out
   output logic                              miso_oe,       // Serial out enable
   input  wire logic [7:0]                   chip_config_byte0, // Config, bit 3 RF priority
   input  wire logic                         rf_ee_req,     // RF side needs EEPROM
   output logic                              reg_wr,        // Register write pulse
   output logic [nts_pkg::REG_AW-1:0]        reg_addr,      // Register address
   output logic [7:0]                        reg_wdata,     // Register write data
   input  wire logic [7:0]                   reg_rdata,     // Register read data
   input  wire logic                         reg_exists,    // Address implemented
   input  wire logic                         reg_writable,  // Address writable
   output logic                              buf_ld_valid,  // Tx buffer byte valid
   output logic [7:0]                        buf_ld_data,   // Tx buffer byte
   input  wire logic                         buf_ld_ready,  // Tx buffer accepts
   output logic                              buf_rd_pop,    // Rx buffer byte consumed
   input  wire logic [7:0]                   buf_rd_data,   // Rx buffer head byte
   output logic                              ee_rd_req,     // EEPROM block fetch
   output logic [nts_pkg::BLK_AW-1:0]        ee_addr,       // EEPROM block address
   input  wire logic [31:0]                  ee_rdata,      // EEPROM block data
   input  wire logic                         ee_blk_exists, // Block implemented
   output logic                              ee_prog,       // Start programming pulse
   output logic [31:0]                       ee_wdata,      // Block program data
   input  wire logic                         ee_busy,       // Programming in progress
   output logic                              ee_abort,      // Abort programming pulse
   output logic                              acc_err_irq,   // Access error event pulse
   output logic                              cmd_valid,     // Direct command pulse
   output logic [5:0]                        cmd_code,      // Direct command code
   output logic                              fifo_ovf       // Write dropped, FIFO full
);
   import nts_pkg::*;

   // -----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // -----------------------------------------------------------------
   logic [1:0] ss_s_q, sck_s_q, mosi_s_q;
   logic       sck_d1_q;

   // Two flops per pin before use
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ss_s_q   <= 2'h3;
         sck_s_q  <= 2'h0;
         mosi_s_q <= 2'h0;
         sck_d1_q <= 1'b0;
      end else begin
         ss_s_q   <= {ss_s_q[0], ss_n};
         sck_s_q  <= {sck_s_q[0], sclk};
         mosi_s_q <= {mosi_s_q[0], mosi};
         sck_d1_q <= sck_s_q[1];
      end
   end

   wire ss_hi   = ss_s_q[1];
   wire sck_fall = sck_d1_q && !sck_s_q[1];
   wire sck_rise = !sck_d1_q && sck_s_q[1];
   wire din     = mosi_s_q[1];

   // -----------------------------------------------------------------
   // Transaction state
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {NTS_IDLE, NTS_OP, NTS_ADDR, NTS_DATA, NTS_SKIP} nts_state_e;
   nts_state_e  st_q;
   logic [2:0]  bit_q;
   logic [7:0]  sh_q;
   logic [7:0]  op_q;
   logic [4:0]  raddr_q;
   logic [6:0]  baddr_q;
   logic [2:0]  bcnt_q;
   logic [5:0]  lcnt_q;
   logic [31:0] ewd_q;
   logic        ee_full_q;
   logic [7:0]  tx_q;
   logic        oe_q;
   logic        ss_d_q;
   logic        rd_pend_q;

   wire [2:0] mode     = op_q[7:5];
   wire       is_cmd   = (op_q[7:6] == OP_CMD);
   wire       byte_end = sck_fall && (bit_q == BIT_LAST);
   wire [7:0] rx_byte  = {sh_q[6:0], din};
   wire       ss_rise  = ss_hi && !ss_d_q;
   wire       rf_pri   = chip_config_byte0[ARBIT_BIT];
   wire       out_mode = (mode == OP_REG_RD) || (mode == OP_EE_RD) ||
                         (mode == OP_BUF_RD) || is_cmd;

   // Next outgoing byte by mode
   wire [7:0] reg_byte = reg_exists ? reg_rdata : 8'h00;
   wire [31:0] ee_blk  = ee_blk_exists ? ee_rdata : 32'h0000_0000;
   wire [7:0] ee_byte  = ee_blk[31 - 8*bcnt_q[1:0] -: 8];
   wire       cmd_rej  = rf_pri && rf_ee_req;
   wire [7:0] arg_byte = cmd_rej ? ARG_REJECT : ARG_ACCEPT;
   wire [7:0] nxt_byte = (mode == OP_REG_RD) ? reg_byte :
                         (mode == OP_EE_RD)  ? ee_byte  :
                         (mode == OP_BUF_RD) ? buf_rd_data :
                         is_cmd              ? arg_byte : 8'h00;

   // -----------------------------------------------------------------
   // Serial engine
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst || ss_hi) begin
         st_q      <= NTS_IDLE;
         bit_q     <= 3'h0;
         sh_q      <= 8'h00;
         oe_q      <= 1'b0;
         tx_q      <= 8'h00;
         bcnt_q    <= 3'h0;
         lcnt_q    <= 6'h00;
         rd_pend_q <= 1'b0;
         if (rst) begin
            op_q      <= 8'h00;
            raddr_q   <= 5'h00;
            baddr_q   <= 7'h00;
            ewd_q     <= 32'h0000_0000;
            ee_full_q <= 1'b0;
         end else if (ss_rise) begin
            ee_full_q <= 1'b0;
         end
      end else begin
         if (st_q == NTS_IDLE) begin
            st_q      <= NTS_OP;
            ee_full_q <= 1'b0;
         end
         if (sck_fall) begin
            bit_q <= bit_q + 3'h1;
            sh_q  <= rx_byte;
         end
         // First rise of a byte shows the preloaded MSB, later rises shift
         if (sck_rise && oe_q && bit_q != 3'h0) tx_q <= {tx_q[6:0], 1'b0};
         if (byte_end) begin
            case (st_q)
               NTS_OP: begin
                  op_q    <= rx_byte;
                  raddr_q <= rx_byte[4:0];
                  if (rx_byte[7:5] == OP_EE_WR || rx_byte[7:5] == OP_EE_RD)
                     st_q <= NTS_ADDR;
                  else
                     st_q <= NTS_DATA;
                  if (rx_byte[7:5] == OP_REG_RD || rx_byte[7:5] == OP_BUF_RD ||
                      rx_byte[7:6] == OP_CMD)
                     rd_pend_q <= 1'b1;
               end
               NTS_ADDR: begin
                  baddr_q <= rx_byte[7:1];
                  st_q    <= NTS_DATA;
                  if (mode == OP_EE_RD) rd_pend_q <= 1'b1;
               end
               NTS_DATA: begin
                  if (mode == OP_REG_WR) raddr_q <= raddr_q + 5'h01;
                  if (mode == OP_EE_WR) begin
                     if (!ee_full_q) begin
                        ewd_q  <= {ewd_q[23:0], rx_byte};
                        bcnt_q <= bcnt_q + 3'h1;
                        if (bcnt_q == EE_BYTES - 3'h1) ee_full_q <= 1'b1;
                     end
                  end
                  if (mode == OP_BUF_LD && lcnt_q != BUF_DEPTH)
                     lcnt_q <= lcnt_q + 6'h01;
                  if (out_mode && !is_cmd) rd_pend_q <= 1'b1;
                  if (is_cmd) st_q <= NTS_SKIP;
               end
               NTS_SKIP: st_q <= NTS_SKIP;
               default: st_q <= NTS_IDLE;
            endcase
         end
         // Load next read byte once the address is known
         if (rd_pend_q && !byte_end) begin
            rd_pend_q <= 1'b0;
            oe_q      <= (st_q != NTS_SKIP);
            tx_q      <= nxt_byte;
            if (mode == OP_REG_RD && st_q == NTS_DATA && bit_q == 3'h0 && oe_q)
               raddr_q <= raddr_q;
            if (mode == OP_EE_RD) begin
               bcnt_q <= (bcnt_q == EE_BYTES - 3'h1) ? 3'h0 : bcnt_q + 3'h1;
               if (bcnt_q == EE_BYTES - 3'h1) baddr_q <= baddr_q + 7'h01;
            end
         end
         if (byte_end && st_q == NTS_DATA && mode == OP_REG_RD)
            raddr_q <= raddr_q + 5'h01;
      end
   end

   // Tracks slave select for its rising edge
   always_ff @(posedge clk_sys) begin
      if (rst) ss_d_q <= 1'b1;
      else     ss_d_q <= ss_hi;
   end

   // Serial output drives only during read shifting
   assign miso_o  = tx_q[7];
   assign miso_oe = oe_q && !ss_hi;

   // -----------------------------------------------------------------
   // Write FIFO: register and buffer bytes {kind, addr, data}
   // -----------------------------------------------------------------
   logic [13:0] f_in, f_out;
   logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   wire         data_byte = byte_end && st_q == NTS_DATA;
   wire         wr_reg    = data_byte && mode == OP_REG_WR;
   wire         wr_buf    = data_byte && mode == OP_BUF_LD && lcnt_q != BUF_DEPTH;
   assign f_in_valid = wr_reg || wr_buf;
   assign f_in       = {wr_buf, raddr_q, rx_byte};
   wire   f_is_buf   = f_out[13];
   assign f_out_ready = f_is_buf ? buf_ld_ready : 1'b1;
   assign fifo_ovf   = f_in_valid && !f_in_ready;

   nts_fifo #(.WIDTH(14), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .in_data  (f_in),
      .in_valid (f_in_valid),
      .in_ready (f_in_ready),
      .out_data (f_out),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready)
   );

   // FIFO drain to registers and transmit buffer
   assign reg_wr       = f_out_valid && !f_is_buf && reg_exists && reg_writable;
   assign reg_addr     = (f_out_valid && !f_is_buf) ? f_out[12:8] : raddr_q;
   assign reg_wdata    = f_out[7:0];
   assign buf_ld_valid = f_out_valid && f_is_buf;
   assign buf_ld_data  = f_out[7:0];

   // -----------------------------------------------------------------
   // Buffer read consumption, EEPROM and command strobes
   // -----------------------------------------------------------------
   wire rd_started = (mode == OP_BUF_RD) && st_q == NTS_DATA && oe_q;
   assign buf_rd_pop = rd_started && (byte_end ||
                       (ss_rise && bit_q != 3'h0));

   logic ee_arm_q;
   // Remember a complete EEPROM write until slave select rises
   always_ff @(posedge clk_sys) begin
      if (rst) ee_arm_q <= 1'b0;
      else if (ss_rise) ee_arm_q <= 1'b0;
      else if (mode == OP_EE_WR && ee_full_q && !ss_hi) ee_arm_q <= 1'b1;
   end

   assign ee_prog  = ss_rise && ee_arm_q;
   assign ee_wdata = ewd_q;
   assign ee_addr  = baddr_q;
   assign ee_rd_req = rd_pend_q && mode == OP_EE_RD && bcnt_q == 3'h0;
   assign ee_abort = ee_busy && rf_pri && rf_ee_req;
   assign acc_err_irq = ee_abort;
   assign cmd_valid = byte_end && st_q == NTS_OP && rx_byte[7:6] == OP_CMD;
   assign cmd_code  = rx_byte[5:0];
endmodule : nts_spi_port

/* File: tb/nts_spi_host.sv */
// Host microcontroller model acting as SPI master
`timescale 1ns/1ns
module nts_spi_host (
   input  wire logic clk_sys, // Bench clock
   input  wire logic miso,    // Resolved data line
   output logic      ss_n,    // Select
   output logic      sclk,    // Serial clock, low between frames
   output logic      mosi     // Serial data
);
   // ----------------------------------------------------------------
   // Pin tasks
   // ----------------------------------------------------------------
   initial begin
      ss_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick
   // Select or release, then settle so select edges stay apart
   task automatic sel(input logic v);
      @(posedge clk_sys);
      ss_n <= v;
      tick(4);
   endtask : sel
   // Shift nb bits MSB first, hp cycles per clock phase
   task automatic xfer(input logic [7:0] tx, input int nb, input int hp, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nb; i--) begin
         @(posedge clk_sys);
         mosi <= tx[i];
         sclk <= 1'b1;
         tick(hp);
         rx[i] = miso;
         sclk <= 1'b0;
         tick(hp - 1);
      end
   endtask : xfer
endmodule : nts_spi_host

/* File: tb/nts_spi_port_sva.sv */
// Checker for the NFC tag SPI host port pins and events
`timescale 1ns/1ns
module nts_spi_port_sva
   import nts_pkg::*;
(
   input wire logic       clk_sys,           // Clock
   input wire logic       rst,               // Reset
   input wire logic       ss_n,              // Select
   input wire logic       miso_oe,           // Out enable
   input wire logic [7:0] chip_config_byte0, // Config
   input wire logic       rf_ee_req,         // RF request
   input wire logic       reg_wr,            // Reg write
   input wire logic       reg_exists,        // Reg present
   input wire logic       reg_writable,      // Reg writable
   input wire logic       buf_ld_valid,      // Load valid
   input wire logic [7:0] buf_ld_data,       // Load byte
   input wire logic       buf_ld_ready,      // Load ready
   input wire logic       buf_rd_pop,        // Pop
   input wire logic       ee_rd_req,         // Block fetch
   input wire logic       ee_prog,           // Program
   input wire logic       ee_busy,           // Busy
   input wire logic       ee_abort,          // Abort
   input wire logic       acc_err_irq,       // Access error
   input wire logic       cmd_valid          // Command
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // RF owns the EEPROM while programming
   wire rf_win = ee_busy && chip_config_byte0[ARBIT_BIT] && rf_ee_req;
   property p_oe_idle; ss_n [*4] |-> !miso_oe; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("miso driven while idle");
   property p_prog_ss; ee_prog |-> ss_n ##1 !ee_prog; endproperty
   a_prog_ss: assert property (p_prog_ss) else $error("program not at select rise");
   property p_abort; ee_abort |-> rf_win || $past(rf_win); endproperty
   a_abort: assert property (p_abort) else $error("abort without RF priority");
   property p_irq; acc_err_irq |-> rf_win || $past(rf_win); endproperty
   a_irq: assert property (p_irq) else $error("access error without cause");
   property p_no_abort; !rf_win && $past(!rf_win) |-> !ee_abort; endproperty
   a_no_abort: assert property (p_no_abort) else $error("abort under host priority");
   property p_ld_hold; buf_ld_valid && !buf_ld_ready |=> buf_ld_valid && $stable(buf_ld_data);
   endproperty
   a_ld_hold: assert property (p_ld_hold) else $error("load byte dropped");
   property p_wr_guard; reg_wr |-> reg_exists && reg_writable; endproperty
   a_wr_guard: assert property (p_wr_guard) else $error("write to read-only");
   property p_cmd_sel; cmd_valid |-> $past(!ss_n, 3); endproperty
   a_cmd_sel: assert property (p_cmd_sel) else $error("command outside frame");
   property p_rd_sel; ee_rd_req |-> $past(!ss_n, 2); endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("fetch outside frame");
   property p_pop; buf_rd_pop |=> !buf_rd_pop; endproperty
   a_pop: assert property (p_pop) else $error("byte popped twice");
   c_prog: cover property (ee_prog);
   c_abort: cover property (ee_abort);
   c_pop: cover property (buf_rd_pop);
endmodule : nts_spi_port_sva

bind nts_spi_port nts_spi_port_sva u_sva (.clk_sys(clk_sys), .rst(rst), .ss_n(ss_n),
   .miso_oe(miso_oe), .chip_config_byte0(chip_config_byte0), .rf_ee_req(rf_ee_req),
   .reg_wr(reg_wr), .reg_exists(reg_exists), .reg_writable(reg_writable),
   .buf_ld_valid(buf_ld_valid), .buf_ld_data(buf_ld_data), .buf_ld_ready(buf_ld_ready),
   .buf_rd_pop(buf_rd_pop), .ee_rd_req(ee_rd_req), .ee_prog(ee_prog), .ee_busy(ee_busy),
   .ee_abort(ee_abort), .acc_err_irq(acc_err_irq), .cmd_valid(cmd_valid));

/* File: tb/nts_spi_port_tb.sv */
// Self-checking bench for the NFC tag SPI host port
`timescale 1ns/1ns
module nts_spi_port_tb;
   import nts_pkg::*;
   // ----------------------------------------------------------------
   // Pins, responders and event logs
   // ----------------------------------------------------------------
   logic        clk_sys, rst, flip, rf_ee_req, ee_busy, fifo_ovf;
   logic        buf_ld_ready, ss_n, sclk, mosi, miso_o, miso_oe, reg_wr;
   logic        buf_ld_valid, buf_rd_pop, ee_rd_req, ee_prog, ee_abort, acc_err_irq;
   logic        cmd_valid, reg_exists, reg_writable, ee_blk_exists;
   logic [7:0]  cfg, buf_rd_data, reg_wdata, buf_ld_data, rx, ld_last, reg_rdata;
   logic [4:0]  reg_addr;
   logic [6:0]  ee_addr;
   logic [5:0]  cmd_code, code_last;
   logic [31:0] ee_wdata, ee_rdata;
   logic [38:0] prog_word;
   logic [12:0] wr_log[$];
   int          err_count = 0, n_checks = 0, cyc = 0, n_ld, n_pop, n_prog, n_abort, n_irq;
   int          n_ovf;
   wire         miso;
   // Released line keeps changing; register and EEPROM responders
   assign miso          = miso_oe ? miso_o : flip;
   assign reg_rdata     = {3'h0, reg_addr} ^ 8'h5A;
   assign reg_exists    = reg_addr != 5'h07;
   assign reg_writable  = reg_addr != 5'h04;
   assign ee_rdata      = {4{1'b0, ee_addr}};
   assign ee_blk_exists = ee_addr < 7'h10;
   nts_spi_port DUT (.clk_sys(clk_sys), .rst(rst), .ss_n(ss_n), .sclk(sclk), .mosi(mosi),
      .miso_o(miso_o), .miso_oe(miso_oe), .chip_config_byte0(cfg), .rf_ee_req(rf_ee_req),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_exists(reg_exists), .reg_writable(reg_writable), .buf_ld_valid(buf_ld_valid),
      .buf_ld_data(buf_ld_data), .buf_ld_ready(buf_ld_ready), .buf_rd_pop(buf_rd_pop),
      .buf_rd_data(buf_rd_data), .ee_rd_req(ee_rd_req), .ee_addr(ee_addr),
      .ee_rdata(ee_rdata), .ee_blk_exists(ee_blk_exists), .ee_prog(ee_prog),
      .ee_wdata(ee_wdata), .ee_busy(ee_busy), .ee_abort(ee_abort),
      .acc_err_irq(acc_err_irq), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .fifo_ovf(fifo_ovf));
   nts_spi_host u_host (.clk_sys(clk_sys), .miso(miso), .ss_n(ss_n), .sclk(sclk), .mosi(mosi));
   always #25 clk_sys = ~clk_sys;
   // Far-side responders, event logs and hang limit
   always @(posedge clk_sys) begin
      flip <= ~flip;
      buf_ld_ready <= ~buf_ld_ready;
      cyc <= cyc + 1;
      if (reg_wr) wr_log.push_back({reg_addr, reg_wdata});
      if (buf_ld_valid && buf_ld_ready) n_ld++;
      if (buf_ld_valid && buf_ld_ready) ld_last <= buf_ld_data;
      if (buf_rd_pop) n_pop++;
      if (buf_rd_pop) buf_rd_data <= buf_rd_data + 8'h11;
      if (ee_prog) n_prog++;
      if (ee_prog) prog_word <= {ee_addr, ee_wdata};
      if (ee_abort) n_abort++;
      if (acc_err_irq) n_irq++;
      if (fifo_ovf) n_ovf++;
      if (cmd_valid) code_last <= cmd_code;
      if (cyc == 30000) begin
         err_count++;
         finish_test();
      end
   end
   // ----------------------------------------------------------------
   // Checks and scenarios
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic put(input logic [7:0] tx, input int nb = 8, input int hp = 4);
      u_host.xfer(tx, nb, hp, rx);
   endtask : put
   task automatic t_reg_wr;
      wr_log.delete();
      u_host.sel(1'b0);
      put(8'h03);
      put(8'hA5);
      put(8'h3C);
      put(8'h77);
      put(8'hEE, 5);
      u_host.sel(1'b1);
      u_host.tick(20);
      check("write count", wr_log.size(), 2);
      check("write 0", wr_log[0], {5'h03, 8'hA5});
      check("write 1", wr_log[1], {5'h05, 8'h77});
      $display("test reg_wr done");
   endtask : t_reg_wr
   task automatic t_reg_rd;
      u_host.sel(1'b0);
      put(8'h26);
      put(8'h00);
      check("read 6", rx, 8'h5C);
      put(8'h00);
      check("read 7", rx, 8'h00);
      put(8'h00);
      check("read 8", rx, 8'h52);
      u_host.sel(1'b1);
      check("oe idle", miso_oe, 1'b0);
      $display("test reg_rd done");
   endtask : t_reg_rd
   task automatic t_ee;
      u_host.sel(1'b0);
      put(8'h40);
      put(8'h0B);
      for (int i = 1; i <= 5; i++) put(8'h11 * i);
      check("no early program", n_prog, 0);
      u_host.sel(1'b1);
      check("program count", n_prog, 1);
      check("program word", prog_word, {7'h05, 32'h1122_3344});
      u_host.sel(1'b0);
      put(8'h7F, 8, 10);
      put(8'h1E, 8, 10);
      for (int i = 0; i < 8; i++) begin
         put(8'h00, 8, 10);
         check("ee byte", rx, (i < 4) ? 8'h0F : 8'h00);
      end
      u_host.sel(1'b1);
      $display("test eeprom done");
   endtask : t_ee
   task automatic t_buf;
      u_host.sel(1'b0);
      put(8'h80);
      for (int i = 0; i < 33; i++) put(8'(i));
      u_host.sel(1'b1);
      check("load count", n_ld, 32);
      check("load last", ld_last, 8'h1F);
      check("no overflow", n_ovf, 0);
      u_host.sel(1'b0);
      put(8'hA0);
      put(8'h00);
      check("buf byte 0", rx, 8'h40);
      put(8'h00);
      check("buf byte 1", rx, 8'h51);
      put(8'h00, 3);
      u_host.sel(1'b1);
      check("pop count", n_pop, 3);
      $display("test buffer done");
   endtask : t_buf
   task automatic t_cmd_rf;
      for (int k = 0; k < 2; k++) begin
         cfg <= {4'h0, k[0], 3'h0};
         rf_ee_req <= k[0];
         u_host.sel(1'b0);
         put(8'hC5);
         put(8'h00);
         u_host.sel(1'b1);
         check("argument", rx, k ? ARG_REJECT : ARG_ACCEPT);
         check("code", code_last, 6'h05);
      end
      ee_busy <= 1'b1;
      u_host.tick(5);
      check("abort seen", n_abort > 0, 1'b1);
      check("irq seen", n_irq > 0, 1'b1);
      cfg <= 8'h00;
      u_host.tick(1);
      n_abort = 0;
      u_host.tick(5);
      check("host priority", n_abort, 0);
      ee_busy <= 1'b0;
      $display("test command done");
   endtask : t_cmd_rf
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      flip = 1'b0;
      rf_ee_req = 1'b0;
      ee_busy = 1'b0;
      buf_ld_ready = 1'b0;
      cfg = 8'h00;
      buf_rd_data = 8'h40;
      n_ovf = 0;
      n_ld = 0;
      n_pop = 0;
      n_prog = 0;
      n_abort = 0;
      n_irq = 0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      u_host.tick(4);
      t_reg_wr();
      t_reg_rd();
      t_ee();
      t_buf();
      t_cmd_rf();
      finish_test();
   end
endmodule : nts_spi_port_tb
